// ---- shared/ibi_pkg.sv ----
// Constants and types for the slot bus interface pin block
`default_nettype none
package ibi_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] IBI_OFF_MISC = 8'h00;
  localparam logic [7:0] IBI_OFF_MEM = 8'h04;
  localparam logic [7:0] IBI_OFF_PORTA = 8'h08;
  localparam logic [7:0] IBI_OFF_CLK = 8'h0c;
  localparam logic [7:0] IBI_OFF_CTRL = 8'h10;
  localparam logic [7:0] IBI_OFF_MAP_BASE = 8'h14;
  localparam logic [7:0] IBI_OFF_MAP_MASK = 8'h18;
  localparam logic [7:0] IBI_OFF_STATUS = 8'h1c;

  // Field positions
  localparam int unsigned IBI_BIT_CACHE_SEL = 3;
  localparam int unsigned IBI_BIT_WAKE_EN = 7;
  localparam int unsigned IBI_BIT_PORTA_A20 = 1;
  localparam int unsigned IBI_BIT_CLK_SRC = 2;
  localparam int unsigned IBI_BIT_IOCHK_EN = 0;
  localparam int unsigned IBI_BIT_MAP_EN = 1;

  // Values after reset
  localparam logic [7:0] IBI_RST_MISC = 8'h00;
  localparam logic [7:0] IBI_RST_MEM = 8'h00;
  localparam logic [7:0] IBI_RST_PORTA = 8'h00;
  localparam logic [2:0] IBI_RST_CLK = 3'h0;
  localparam logic [7:0] IBI_RST_CTRL = 8'h00;
  localparam logic [23:0] IBI_RST_MAP = 24'h000000;

  // Default CPU wait states per target kind
  localparam logic [3:0] IBI_WAIT_8BIT = 4'h4;
  localparam logic [3:0] IBI_WAIT_16BIT = 4'h1;
  localparam logic [3:0] IBI_WAIT_ROM = 4'h3;

  typedef enum logic [1:0] {
    IBI_KIND_8BIT = 2'h0,
    IBI_KIND_16BIT = 2'h1,
    IBI_KIND_ROM = 2'h2
  } ibi_kind_e;

  typedef enum logic [1:0] {
    IBI_PIN_IDLE = 2'h0,
    IBI_PIN_WAKE = 2'h1,
    IBI_PIN_MISS = 2'h3
  } ibi_pin_e;

  // Gray sequence along the usual path
  typedef enum logic [1:0] {
    IBI_RDY_IDLE = 2'h0,
    IBI_RDY_LOW = 2'h1,
    IBI_RDY_HIGH = 2'h3,
    IBI_RDY_DONE = 2'h2
  } ibi_rdy_e;
endpackage
`default_nettype wire

// ---- verilog/ibi_bus_if.sv ----
// Slot bus interface pin logic with AHB-Lite register slave
`default_nettype none
// Operation
// - Wake/miss pin mode from two config bits
// - Wake output low during DMA or master
// - AEN high when hold ack and master high
// - BALE pulse per non-DRAM CPU cycle
// - BALE held high during hold acknowledge
// - DRQ0-3 8-bit, DRQ5-7 16-bit, no DRQ4
// - Low IOCHRDY extends any current cycle
// - Default waits: 8-bit 4, 16-bit 1, ROM 3
// - Drive IOCHRDY low for local hold access
// - Low channel check raises NMI when enabled
// - Bus clock from chosen source, divide 2-8
// - After local ready, IOCHRDY high once, release
module ibi_bus_if
  import ibi_pkg::*;
(
  input wire logic i_ref_clk,                 // 200 MHz clock
  input wire logic i_resetn,                  // Async reset, active low
  input wire logic i_hsel,                    // AHB slave select
  input wire logic [31:0] i_haddr,            // AHB address
  input wire logic [1:0] i_htrans,            // AHB transfer type
  input wire logic i_hwrite,                  // AHB write
  input wire logic [2:0] i_hsize,             // AHB size, word only
  input wire logic [31:0] i_hwdata,           // AHB write data
  input wire logic i_hready,                  // AHB bus ready
  output logic [31:0] o_hrdata,               // AHB read data
  output logic o_hreadyout,                   // AHB slave ready
  output logic o_hresp,                       // AHB response, OKAY
  input wire logic i_hlda,                    // Hold acknowledge
  input wire logic i_master_n,                // Bus master request, low
  input wire logic i_sleep_req_n,             // Low-power request
  input wire logic i_wake_miss_in,            // Shared pin level in
  output logic o_wake_miss_out,               // Shared pin drive level
  output logic o_wake_miss_oe,                // Shared pin enable
  output logic o_cache_miss,                  // Cache miss seen
  output logic o_aen,                         // Address enable
  input wire logic i_cpu_cycle_start,         // CPU cycle start pulse
  input wire logic i_cpu_cycle_dram,          // Cycle hits on-board DRAM
  input wire logic [1:0] i_cpu_cycle_kind,    // Target kind
  output logic o_bale,                        // Address latch enable
  output logic o_cpu_ready,                   // CPU cycle end pulse
  input wire logic i_addr20_gate_internal,    // Internal A20 gate
  output logic o_addr20_block_n,              // A20 block output
  input wire logic i_bus_osc_in,              // Bus oscillator level
  input wire logic i_cpu_double_clock,        // CPU double clock level
  output logic o_bus_clk,                     // Divided bus clock
  input wire logic [3:0] i_drq_8bit,          // DRQ0-DRQ3
  input wire logic [2:0] i_drq_16bit,         // DRQ5-DRQ7
  output logic [7:0] o_dma_req,               // Requests to DMA
  input wire logic i_iochk_n,                 // Channel check, low
  output logic o_nmi,                         // NMI to processor
  input wire logic i_iochrdy_in,              // IOCHRDY pin level
  output logic o_iochrdy_out,                 // IOCHRDY drive level
  output logic o_iochrdy_oe,                  // IOCHRDY enable
  output logic o_cycle_hold,                  // Extend current cycle
  input wire logic i_cycle_valid,             // DMA/master cycle valid
  input wire logic [23:0] i_cycle_addr,       // DMA/master address
  input wire logic i_local_ready_n            // Local bus ready, low
);

  // Software registers
  logic [7:0] misc_setup_reg;
  logic [7:0] memory_setup_reg;
  logic [7:0] port_a;
  logic [2:0] clk_cfg;
  logic [7:0] ctrl;
  logic [23:0] map_base;
  logic [23:0] map_mask;

  // Bus slave state
  logic dp_write;
  logic [7:0] dp_addr;

  // Block state
  ibi_pin_e pin_mode;
  ibi_rdy_e rdy_state;
  ibi_rdy_e next_rdy_state;
  logic cpu_busy;
  logic [3:0] wait_cnt;
  logic src_prev;
  logic [1:0] div_cnt;

  // AHB decode
  wire addr_phase = i_hsel & i_htrans[1] & i_hready;
  wire addr_hi_ok = (i_haddr[31:8] == 24'h000000);
  wire rd_req = addr_phase & ~i_hwrite & addr_hi_ok;
  wire wr_misc = dp_write & (dp_addr == IBI_OFF_MISC);
  wire wr_mem = dp_write & (dp_addr == IBI_OFF_MEM);
  wire wr_porta = dp_write & (dp_addr == IBI_OFF_PORTA);
  wire wr_clk = dp_write & (dp_addr == IBI_OFF_CLK);
  wire wr_ctrl = dp_write & (dp_addr == IBI_OFF_CTRL);
  wire wr_base = dp_write & (dp_addr == IBI_OFF_MAP_BASE);
  wire wr_mask = dp_write & (dp_addr == IBI_OFF_MAP_MASK);

  wire [31:0] status_word = {20'h00000, wait_cnt, cpu_busy, rdy_state,
                             pin_mode, o_nmi, o_aen, i_hlda};
  wire [7:0] ra = i_haddr[7:0];
  wire [31:0] rd_data =
    (ra == IBI_OFF_MISC) ? {24'h000000, misc_setup_reg} :
    (ra == IBI_OFF_MEM) ? {24'h000000, memory_setup_reg} :
    (ra == IBI_OFF_PORTA) ? {24'h000000, port_a} :
    (ra == IBI_OFF_CLK) ? {29'h00000000, clk_cfg} :
    (ra == IBI_OFF_CTRL) ? {24'h000000, ctrl} :
    (ra == IBI_OFF_MAP_BASE) ? {8'h00, map_base} :
    (ra == IBI_OFF_MAP_MASK) ? {8'h00, map_mask} :
    (ra == IBI_OFF_STATUS) ? status_word : 32'h00000000;

  // Pin mode, cache select dominates wake enable
  wire cache_select_bit = misc_setup_reg[IBI_BIT_CACHE_SEL];
  wire wake_en = memory_setup_reg[IBI_BIT_WAKE_EN];
  wire ibi_pin_e next_pin_mode = cache_select_bit ? IBI_PIN_MISS :
                                 wake_en ? IBI_PIN_WAKE : IBI_PIN_IDLE;

  // CPU cycle wait selection
  wire [3:0] kind_wait =
    (i_cpu_cycle_kind == IBI_KIND_8BIT) ? IBI_WAIT_8BIT :
    (i_cpu_cycle_kind == IBI_KIND_16BIT) ? IBI_WAIT_16BIT :
    IBI_WAIT_ROM;
  wire cpu_take = i_cpu_cycle_start & ~i_cpu_cycle_dram & ~cpu_busy;
  wire cpu_finish = cpu_busy & (wait_cnt == 4'h0) & i_iochrdy_in;

  // Bus clock divider, inputs already synchronous
  wire clk_src = clk_cfg[IBI_BIT_CLK_SRC] ? i_bus_osc_in
                                          : i_cpu_double_clock;
  wire src_rise = clk_src & ~src_prev;
  wire div_wrap = (div_cnt == clk_cfg[1:0]);

  // Local peripheral map decode
  wire map_en = ctrl[IBI_BIT_MAP_EN];
  wire local_hit = map_en &
                   ((i_cycle_addr & map_mask) == (map_base & map_mask));
  wire local_req = i_hlda & i_cycle_valid & local_hit;

  always_comb begin
    case (rdy_state)
      IBI_RDY_IDLE: begin
        next_rdy_state = local_req ? IBI_RDY_LOW : IBI_RDY_IDLE;
      end
      IBI_RDY_LOW: begin
        if (!i_local_ready_n) begin
          next_rdy_state = IBI_RDY_HIGH;
        end else if (!local_req) begin
          next_rdy_state = IBI_RDY_IDLE;
        end else begin
          next_rdy_state = IBI_RDY_LOW;
        end
      end
      IBI_RDY_HIGH: begin
        next_rdy_state = IBI_RDY_DONE;
      end
      IBI_RDY_DONE: begin
        // Stay released until this cycle ends, no second drive
        next_rdy_state = i_cycle_valid ? IBI_RDY_DONE : IBI_RDY_IDLE;
      end
      default: begin
        next_rdy_state = IBI_RDY_IDLE;
      end
    endcase
  end

  // AHB slave, zero wait states
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      dp_write <= addr_phase & i_hwrite & addr_hi_ok;
      dp_addr <= addr_phase ? i_haddr[7:0] : dp_addr;
      o_hrdata <= rd_req ? rd_data : 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      misc_setup_reg <= IBI_RST_MISC;
      memory_setup_reg <= IBI_RST_MEM;
      port_a <= IBI_RST_PORTA;
      clk_cfg <= IBI_RST_CLK;
      ctrl <= IBI_RST_CTRL;
      map_base <= IBI_RST_MAP;
      map_mask <= IBI_RST_MAP;
    end else begin
      misc_setup_reg <= wr_misc ? i_hwdata[7:0] : misc_setup_reg;
      memory_setup_reg <= wr_mem ? i_hwdata[7:0] : memory_setup_reg;
      port_a <= wr_porta ? i_hwdata[7:0] : port_a;
      clk_cfg <= wr_clk ? i_hwdata[2:0] : clk_cfg;
      ctrl <= wr_ctrl ? i_hwdata[7:0] : ctrl;
      map_base <= wr_base ? i_hwdata[23:0] : map_base;
      map_mask <= wr_mask ? i_hwdata[23:0] : map_mask;
    end
  end

  // Pin level outputs
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_mode <= IBI_PIN_IDLE;
      o_wake_miss_oe <= 1'b0;
      o_wake_miss_out <= 1'b1;
      o_cache_miss <= 1'b0;
      o_aen <= 1'b0;
      o_bale <= 1'b0;
      o_addr20_block_n <= 1'b0;
      o_dma_req <= 8'h00;
      o_nmi <= 1'b0;
      o_cycle_hold <= 1'b0;
    end else begin
      pin_mode <= next_pin_mode;
      o_wake_miss_oe <= (pin_mode == IBI_PIN_WAKE);
      o_wake_miss_out <= ~i_hlda;
      o_cache_miss <= (pin_mode == IBI_PIN_MISS) & ~i_wake_miss_in;
      o_aen <= i_hlda & i_master_n;
      o_bale <= i_hlda |
                (i_cpu_cycle_start & ~i_cpu_cycle_dram);
      o_addr20_block_n <= i_addr20_gate_internal |
                          port_a[IBI_BIT_PORTA_A20];
      o_dma_req <= {i_drq_16bit, 1'b0, i_drq_8bit};
      o_nmi <= ctrl[IBI_BIT_IOCHK_EN] & ~i_iochk_n;
      o_cycle_hold <= ~i_iochrdy_in;
    end
  end

  // CPU cycle wait states; IOCHRDY low holds the end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cpu_busy <= 1'b0;
      wait_cnt <= 4'h0;
      o_cpu_ready <= 1'b0;
    end else begin
      o_cpu_ready <= cpu_finish;
      if (cpu_take) begin
        cpu_busy <= 1'b1;
        wait_cnt <= kind_wait;
      end else if (cpu_finish) begin
        cpu_busy <= 1'b0;
      end else if (cpu_busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end

  // Bus clock: toggle every (code+1) source edges gives 2,4,6,8
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      src_prev <= 1'b0;
      div_cnt <= 2'h0;
      o_bus_clk <= 1'b0;
    end else begin
      src_prev <= clk_src;
      if (src_rise) begin
        div_cnt <= div_wrap ? 2'h0 : div_cnt + 2'h1;
        o_bus_clk <= div_wrap ? ~o_bus_clk : o_bus_clk;
      end
    end
  end

  // IOCHRDY drive, registered from the next state
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdy_state <= IBI_RDY_IDLE;
      o_iochrdy_oe <= 1'b0;
      o_iochrdy_out <= 1'b1;
    end else begin
      rdy_state <= next_rdy_state;
      o_iochrdy_oe <= (next_rdy_state == IBI_RDY_LOW) |
                      (next_rdy_state == IBI_RDY_HIGH);
      o_iochrdy_out <= (next_rdy_state == IBI_RDY_HIGH);
    end
  end

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_start_8bit;
    cpu_take && i_cpu_cycle_kind == IBI_KIND_8BIT;
  endsequence
  sequence s_start_rom;
    cpu_take && i_cpu_cycle_kind == IBI_KIND_ROM;
  endsequence

  property p_pin_idle;
    (pin_mode == IBI_PIN_IDLE) |=> !o_wake_miss_oe && !o_cache_miss;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("shared pin driven in idle mode");
  property p_wake_low;
    (pin_mode == IBI_PIN_WAKE) && i_hlda |=>
      o_wake_miss_oe && !o_wake_miss_out;
  endproperty
  a_wake_low: assert property (p_wake_low)
    else $error("wake output not low during hold");
  property p_aen;
    i_hlda && i_master_n |=> o_aen;
  endproperty
  a_aen: assert property (p_aen)
    else $error("AEN not active for DMA cycle");
  property p_bale_dram;
    !i_hlda && i_cpu_cycle_start && i_cpu_cycle_dram |=> !o_bale;
  endproperty
  a_bale_dram: assert property (p_bale_dram)
    else $error("BALE pulsed for DRAM cycle");
  property p_bale_hold;
    i_hlda [*2] |=> o_bale;
  endproperty
  a_bale_hold: assert property (p_bale_hold)
    else $error("BALE low while hold acknowledged");
  property p_a20;
    i_addr20_gate_internal |=> o_addr20_block_n;
  endproperty
  a_a20: assert property (p_a20)
    else $error("A20 block missing gate term");
  property p_no_drq4;
    ##1 !o_dma_req[4];
  endproperty
  a_no_drq4: assert property (p_no_drq4)
    else $error("channel 4 request seen outside");
  property p_extend;
    cpu_busy && wait_cnt == 4'h0 && !i_iochrdy_in |=> !o_cpu_ready;
  endproperty
  a_extend: assert property (p_extend)
    else $error("cycle ended while IOCHRDY low");
  property p_wait_8bit;
    s_start_8bit |=> !o_cpu_ready [*5] ##1
      (o_cpu_ready || !$past(i_iochrdy_in));
  endproperty
  a_wait_8bit: assert property (p_wait_8bit)
    else $error("8-bit cycle wait count wrong");
  property p_wait_rom;
    s_start_rom |=> !o_cpu_ready [*4] ##1
      (o_cpu_ready || !$past(i_iochrdy_in));
  endproperty
  a_wait_rom: assert property (p_wait_rom)
    else $error("ROM cycle wait count wrong");
  property p_local_low;
    rdy_state == IBI_RDY_IDLE && local_req |=>
      o_iochrdy_oe && !o_iochrdy_out;
  endproperty
  a_local_low: assert property (p_local_low)
    else $error("IOCHRDY not pulled low for local access");
  property p_nmi;
    ctrl[IBI_BIT_IOCHK_EN] && !i_iochk_n |=> o_nmi;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("channel check gave no NMI");
  property p_div;
    src_rise && div_wrap && !wr_clk |=> o_bus_clk != $past(o_bus_clk);
  endproperty
  a_div: assert property (p_div)
    else $error("bus clock did not toggle at wrap");
  property p_release;
    rdy_state == IBI_RDY_LOW && !i_local_ready_n |=>
      o_iochrdy_oe && o_iochrdy_out ##1 !o_iochrdy_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("IOCHRDY not driven high once then released");

endmodule
`default_nettype wire

// ---- testbench/ibi_card_model.sv ----
// Model of a slot bus card and a local bus device on IOCHRDY
`default_nettype none
module ibi_card_model (
  input wire logic i_ref_clk,  // 200 MHz clock
  input wire logic i_stretch,  // Card holds IOCHRDY low while high
  input wire logic i_oe,       // Controller IOCHRDY enable
  input wire logic i_out,      // Controller IOCHRDY level
  output logic o_iochrdy,      // Resolved IOCHRDY wire
  output logic o_local_ready_n // Local device ready, low
);
  timeunit 1ns;
  timeprecision 1ps;
  int lat = 0;
  // Pull-up on the wire, so a released line reads high
  assign o_iochrdy = i_stretch ? 1'b0 : (i_oe ? i_out : 1'b1);
  // Local device answers once, after three cycles of latency
  always @(posedge i_ref_clk) begin
    lat <= (i_oe && !i_out) ? lat + 1 : 0;
    o_local_ready_n <= !(lat == 2);
  end
endmodule
`default_nettype wire

// ---- testbench/test_ibi_bus_if.sv ----
// Self-checking bench for the slot bus interface pin block
`default_nettype none
module test_ibi_bus_if import ibi_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, hsel, hwrite, hlda, master_n, sleep_req_n, pin_drv;
  logic cstart, cdram, gate, osc, dbl, iochk_n, stretch, cvalid;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, ckind;
  logic [3:0] drq8;
  logic [2:0] drq16;
  logic [23:0] caddr;
  logic [7:0] dma_req;
  logic hrdy, hresp, wm_out, wm_oe, miss, aen, bale, cpu_rdy, blk_n;
  logic bus_clk, nmi, rdy_out, rdy_oe, hold, rdy_wire, lrdy_n;
  wire logic wm_pin = wm_oe ? wm_out : pin_drv;
  int error_cnt = 0;
  int checked = 0;
  int tick = 0;
  int at, nb, nh, n;

  ibi_bus_if u_ibi_bus_if (.i_ref_clk(clk), .i_resetn(rstn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_hlda(hlda),
    .i_master_n(master_n), .i_sleep_req_n(sleep_req_n),
    .i_wake_miss_in(wm_pin), .o_wake_miss_out(wm_out),
    .o_wake_miss_oe(wm_oe), .o_cache_miss(miss), .o_aen(aen),
    .i_cpu_cycle_start(cstart), .i_cpu_cycle_dram(cdram),
    .i_cpu_cycle_kind(ckind), .o_bale(bale), .o_cpu_ready(cpu_rdy),
    .i_addr20_gate_internal(gate), .o_addr20_block_n(blk_n),
    .i_bus_osc_in(osc), .i_cpu_double_clock(dbl), .o_bus_clk(bus_clk),
    .i_drq_8bit(drq8), .i_drq_16bit(drq16), .o_dma_req(dma_req),
    .i_iochk_n(iochk_n), .o_nmi(nmi), .i_iochrdy_in(rdy_wire),
    .o_iochrdy_out(rdy_out), .o_iochrdy_oe(rdy_oe), .o_cycle_hold(hold),
    .i_cycle_valid(cvalid), .i_cycle_addr(caddr),
    .i_local_ready_n(lrdy_n));
  ibi_card_model u_ibi_card_model (.i_ref_clk(clk), .i_stretch(stretch),
    .i_oe(rdy_oe), .i_out(rdy_out), .o_iochrdy(rdy_wire),
    .o_local_ready_n(lrdy_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Both clock sources run at fixed periods of 4 and 6 cycles
  always @(posedge clk) begin
    tick <= tick + 1;
    osc <= (tick % 4) < 2;
    dbl <= (tick % 6) < 3;
  end

  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Outputs are read just after the edge, before its updates land
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
    chk(hresp, 1'b0);
  endtask
  // Start one CPU cycle; card may stretch IOCHRDY for st cycles
  task automatic cpu(input logic [1:0] k, input logic dr, input int st);
    at = 0;
    nb = 0;
    nh = 0;
    cstart <= 1'b1;
    ckind <= k;
    cdram <= dr;
    stretch <= (st > 0);
    for (int i = 1; i < 24; i++) begin
      @(posedge clk);
      cstart <= 1'b0;
      if (i == st) stretch <= 1'b0;
      if (bale === 1'b1) nb++;
      if (hold === 1'b1) nh++;
      if (cpu_rdy === 1'b1 && at == 0) at = i - 1;
    end
  endtask
  // Half period of the bus clock, in reference cycles
  task automatic half();
    logic b;
    for (int k = 0; k < 3; k++) begin
      b = bus_clk;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (bus_clk === b && n < 200);
    end
  endtask

  initial begin
    {rstn, hsel, hwrite, hlda, master_n, pin_drv, cstart, cdram} = '0;
    {gate, stretch, cvalid, htrans, ckind, drq8, drq16} = '0;
    {haddr, hwdata, caddr} = '0;
    iochk_n = 1'b1;
    sleep_req_n = 1'b0;
    cyc(4);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rchk(4 * i, 32'h0);
    wr(32'h100, 32'hff);
    rchk(32'h100, 32'h0);
    chk(wm_oe, 1'b0);
    pin_drv <= 1'b0;
    cyc(2);
    chk(miss, 1'b0);
    wr(IBI_OFF_MEM, 32'h80);
    cyc(3);
    chk({wm_oe, wm_out}, 2'h3);
    hlda <= 1'b1;
    master_n <= 1'b1;
    cyc(2);
    chk({wm_out, aen, bale}, 3'h3);
    master_n <= 1'b0;
    cyc(3);
    chk({wm_out, aen, bale}, 3'h1);
    hlda <= 1'b0;
    cyc(2);
    chk({wm_out, aen, bale}, 3'h4);
    wr(IBI_OFF_MISC, 32'h8);
    cyc(4);
    chk({wm_oe, miss}, 2'h1);
    pin_drv <= 1'b1;
    cyc(2);
    chk(miss, 1'b0);
    wr(IBI_OFF_MISC, 32'h0);
    wr(IBI_OFF_MEM, 32'h0);
    cpu(IBI_KIND_8BIT, 1'b0, 0);
    chk(at, IBI_WAIT_8BIT + 32'h2);
    chk(nb, 32'h1);
    chk(nh, 32'h0);
    cpu(IBI_KIND_16BIT, 1'b0, 0);
    chk(at, IBI_WAIT_16BIT + 32'h2);
    chk(nb, 32'h1);
    cpu(IBI_KIND_ROM, 1'b0, 0);
    chk(at, IBI_WAIT_ROM + 32'h2);
    chk(nb, 32'h1);
    cpu(IBI_KIND_16BIT, 1'b1, 0);
    chk(at, 32'h0);
    chk(nb, 32'h0);
    cpu(IBI_KIND_8BIT, 1'b0, 8);
    chk(at, 32'h9);
    chk(nh, 32'h8);
    gate <= 1'b1;
    cyc(2);
    chk(blk_n, 1'b1);
    gate <= 1'b0;
    cyc(2);
    chk(blk_n, 1'b0);
    wr(IBI_OFF_PORTA, 32'h2);
    cyc(2);
    chk(blk_n, 1'b1);
    drq8 <= 4'ha;
    drq16 <= 3'h5;
    cyc(2);
    chk(dma_req, 8'haa);
    drq8 <= 4'h5;
    drq16 <= 3'h2;
    cyc(2);
    chk(dma_req, 8'h45);
    iochk_n <= 1'b0;
    cyc(2);
    chk(nmi, 1'b0);
    wr(IBI_OFF_CTRL, 32'h1);
    cyc(2);
    chk(nmi, 1'b1);
    iochk_n <= 1'b1;
    cyc(2);
    chk(nmi, 1'b0);
    wr(IBI_OFF_MAP_BASE, 32'h0a0000);
    wr(IBI_OFF_MAP_MASK, 32'hff0000);
    wr(IBI_OFF_CTRL, 32'h3);
    hlda <= 1'b1;
    master_n <= 1'b1;
    cvalid <= 1'b1;
    caddr <= 24'h0b1234;
    cyc(3);
    chk(rdy_oe, 1'b0);
    cvalid <= 1'b0;
    @(posedge clk);
    cvalid <= 1'b1;
    caddr <= 24'h0a1234;
    cyc(2);
    chk({rdy_oe, rdy_out}, 2'h2);
    n = 0;
    while (!(rdy_oe === 1'b1 && rdy_out === 1'b1) && n < 12) begin
      @(posedge clk);
      n++;
    end
    chk(n < 12, 1'b1);
    @(posedge clk);
    chk(rdy_oe, 1'b0);
    {hlda, cvalid} <= 2'h0;
    for (int c = 0; c < 4; c++) begin
      wr(IBI_OFF_CLK, {29'h0, c[0], c[1:0]});
      half();
      chk(n, (c + 1) * (c[0] ? 4 : 6));
    end
    close_out();
  end
  // Whole sequence needs a few hundred cycles
  initial begin
    #100us;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
